// ==== logic/tlic_pkg.sv ====
// Constants for the two level interrupt controller.
package tlic_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] TLIC_ADDR_MAIN = 8'hA8;
  localparam logic [7:0] TLIC_ADDR_SEC = 8'hA9;
  localparam logic [7:0] TLIC_ADDR_LVL = 8'hB8;
  localparam logic [7:0] TLIC_RST_MAIN = 8'h00;
  localparam logic [7:0] TLIC_RST_SEC = 8'hA0;
  localparam logic [7:0] TLIC_RST_LVL = 8'h00;
  localparam logic [7:0] TLIC_IMPL_MASK = 8'h7F;
  localparam logic [7:0] TLIC_SEC_ONES = 8'h80;
  localparam logic [7:0] TLIC_RD_NONE = 8'h00;
  // ==========================================================
  // Field positions of the main enable register; level select uses bits 6 to 0 only
  localparam int TLIC_GATE_BIT = 7;
  localparam int TLIC_ADC_BIT = 6;
  localparam int TLIC_T2_BIT = 5;
  localparam int TLIC_UART_BIT = 4;
  localparam int TLIC_T1_BIT = 3;
  localparam int TLIC_EXT1_BIT = 2;
  localparam int TLIC_T0_BIT = 1;
  localparam int TLIC_EXT0_BIT = 0;
  // ==========================================================
  // Field positions of the secondary register
  localparam int TLIC_TIC_LVL_BIT = 6;
  localparam int TLIC_PSM_LVL_BIT = 5;
  localparam int TLIC_SER_LVL_BIT = 4;
  localparam int TLIC_TIC_EN_BIT = 2;
  localparam int TLIC_PSM_EN_BIT = 1;
  localparam int TLIC_SER_EN_BIT = 0;
  // ==========================================================
  // Sources in polling order, index 0 is polled first
  localparam int TLIC_NSRC = 11;
  localparam int TLIC_S_PSM = 0;
  localparam int TLIC_S_WDT = 1;
  localparam int TLIC_S_EXT0 = 2;
  localparam int TLIC_S_ADC = 3;
  localparam int TLIC_S_T0 = 4;
  localparam int TLIC_S_EXT1 = 5;
  localparam int TLIC_S_T1 = 6;
  localparam int TLIC_S_SER = 7;
  localparam int TLIC_S_UART = 8;
  localparam int TLIC_S_T2 = 9;
  localparam int TLIC_S_TIC = 10;
  localparam logic [15:0] TLIC_VEC_EXT0 = 16'h0003;
  localparam logic [15:0] TLIC_VEC_T0 = 16'h000B;
  localparam logic [15:0] TLIC_VEC_EXT1 = 16'h0013;
  localparam logic [15:0] TLIC_VEC_T1 = 16'h001B;
  localparam logic [15:0] TLIC_VEC_UART = 16'h0023;
  localparam logic [15:0] TLIC_VEC_T2 = 16'h002B;
  localparam logic [15:0] TLIC_VEC_ADC = 16'h0033;
  localparam logic [15:0] TLIC_VEC_SER = 16'h003B;
  localparam logic [15:0] TLIC_VEC_PSM = 16'h0043;
  localparam logic [15:0] TLIC_VEC_TIC = 16'h0053;
  localparam logic [15:0] TLIC_VEC_WDT = 16'h005B;
  localparam logic [15:0] TLIC_VEC_NONE = 16'h0000;
  localparam logic [TLIC_NSRC*16-1:0] TLIC_VECS = {
    TLIC_VEC_TIC, TLIC_VEC_T2, TLIC_VEC_UART, TLIC_VEC_SER, TLIC_VEC_T1,
    TLIC_VEC_EXT1, TLIC_VEC_T0, TLIC_VEC_ADC, TLIC_VEC_EXT0, TLIC_VEC_WDT,
    TLIC_VEC_PSM};
endpackage

// ==== logic/tlic_ctrl.sv ====
// Two level interrupt controller with its three registers.
// ==========================================================
`timescale 1ns/1ps
module tlic_ctrl (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Special function register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Request flags.
  input wire logic supply_monitor_request,
  input wire logic watchdog_request,
  input wire logic ext0_request,
  input wire logic adc_primary_ready,
  input wire logic adc_aux_ready,
  input wire logic timer0_overflow,
  input wire logic ext1_request,
  input wire logic timer1_overflow,
  input wire logic spi_request,
  input wire logic twowire_request,
  input wire logic uart_rx_flag,
  input wire logic uart_tx_flag,
  input wire logic timer2_overflow,
  input wire logic timer2_external_flag,
  input wire logic interval_counter_request,
  // Core side.
  input wire logic core_ack,
  input wire logic core_reti,
  output logic irq_push_req,
  output logic [15:0] irq_vector,
  output logic irq_level,
  output logic in_service_high,
  output logic in_service_low
);
  import tlic_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] main_en_ff;
  logic [7:0] lvl_sel_ff;
  logic [7:0] sec_ff;
  logic [7:0] rdata_ff;
  logic req_ff;
  logic [15:0] vec_ff;
  logic lvl_ff;
  logic hi_ff;
  logic lo_ff;

  wire wr_main = sfr_wr && (sfr_addr == TLIC_ADDR_MAIN);
  wire wr_lvl = sfr_wr && (sfr_addr == TLIC_ADDR_LVL);
  wire wr_sec = sfr_wr && (sfr_addr == TLIC_ADDR_SEC);
  wire [7:0] lvl_view = lvl_sel_ff & TLIC_IMPL_MASK;
  wire [7:0] sec_view = (sec_ff & TLIC_IMPL_MASK) | TLIC_SEC_ONES;
  wire [7:0] nxt_rdata =
    (sfr_addr == TLIC_ADDR_MAIN) ? main_en_ff :
    (sfr_addr == TLIC_ADDR_LVL) ? lvl_view :
    (sfr_addr == TLIC_ADDR_SEC) ? sec_view : TLIC_RD_NONE;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_en_ff <= TLIC_RST_MAIN;
      lvl_sel_ff <= TLIC_RST_LVL;
      sec_ff <= TLIC_RST_SEC & TLIC_IMPL_MASK;
      rdata_ff <= TLIC_RD_NONE;
    end else begin
      if (wr_main) main_en_ff <= sfr_wdata;
      if (wr_lvl) lvl_sel_ff <= sfr_wdata & TLIC_IMPL_MASK;
      if (wr_sec) sec_ff <= sfr_wdata & TLIC_IMPL_MASK;
      if (sfr_rd) rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Per source pending, enable and level, in polling order
  logic [TLIC_NSRC-1:0] pend;
  logic [TLIC_NSRC-1:0] en;
  logic [TLIC_NSRC-1:0] lvl;
  assign pend = {interval_counter_request,
    timer2_overflow | timer2_external_flag, uart_rx_flag | uart_tx_flag,
    spi_request | twowire_request, timer1_overflow, ext1_request,
    timer0_overflow, adc_primary_ready | adc_aux_ready, ext0_request,
    watchdog_request, supply_monitor_request};
  assign en = {sec_ff[TLIC_TIC_EN_BIT], main_en_ff[TLIC_T2_BIT],
    main_en_ff[TLIC_UART_BIT], sec_ff[TLIC_SER_EN_BIT],
    main_en_ff[TLIC_T1_BIT], main_en_ff[TLIC_EXT1_BIT],
    main_en_ff[TLIC_T0_BIT], main_en_ff[TLIC_ADC_BIT],
    main_en_ff[TLIC_EXT0_BIT], 1'b1, sec_ff[TLIC_PSM_EN_BIT]};
  assign lvl = {sec_ff[TLIC_TIC_LVL_BIT], lvl_sel_ff[TLIC_T2_BIT],
    lvl_sel_ff[TLIC_UART_BIT], sec_ff[TLIC_SER_LVL_BIT],
    lvl_sel_ff[TLIC_T1_BIT], lvl_sel_ff[TLIC_EXT1_BIT],
    lvl_sel_ff[TLIC_T0_BIT], lvl_sel_ff[TLIC_ADC_BIT],
    lvl_sel_ff[TLIC_EXT0_BIT], lvl_sel_ff[TLIC_EXT0_BIT],
    sec_ff[TLIC_PSM_LVL_BIT]};

  // ==========================================================
  // Level tracking and arbitration
  wire accept = core_ack && req_ff;
  wire nxt_hi = (accept && lvl_ff) ? 1'b1 :
    (core_reti && hi_ff) ? 1'b0 : hi_ff;
  wire nxt_lo = (accept && !lvl_ff) ? 1'b1 :
    (core_reti && !hi_ff) ? 1'b0 : lo_ff;
  wire [TLIC_NSRC-1:0] live = pend & en &
    {TLIC_NSRC{main_en_ff[TLIC_GATE_BIT]}};
  wire [TLIC_NSRC-1:0] elig_hi = live & lvl & {TLIC_NSRC{!nxt_hi}};
  wire [TLIC_NSRC-1:0] elig_lo = live & ~lvl &
    {TLIC_NSRC{!nxt_hi && !nxt_lo}};
  wire hi_any = |elig_hi;
  wire lo_any = |elig_lo;
  wire [TLIC_NSRC-1:0] pick = hi_any ? elig_hi : elig_lo;
  logic [15:0] nxt_vec;

  always_comb begin
    nxt_vec = TLIC_VEC_NONE;
    for (int i = TLIC_NSRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        nxt_vec = TLIC_VECS[i*16 +: 16];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ff <= 1'b0;
      vec_ff <= TLIC_VEC_NONE;
      lvl_ff <= 1'b0;
      hi_ff <= 1'b0;
      lo_ff <= 1'b0;
    end else begin
      req_ff <= hi_any || lo_any;
      vec_ff <= nxt_vec;
      lvl_ff <= hi_any;
      hi_ff <= nxt_hi;
      lo_ff <= nxt_lo;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign irq_push_req = req_ff;
  assign irq_vector = vec_ff;
  assign irq_level = lvl_ff;
  assign in_service_high = hi_ff;
  assign in_service_low = lo_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_gate_blocks_all: assert property (
    !main_en_ff[TLIC_GATE_BIT] |=> !req_ff)
    else $error("request raised while global gate clear");
  a_enable_write: assert property (
    wr_main |=> main_en_ff == $past(sfr_wdata))
    else $error("main enable register did not take write");
  a_level_bit7_zero: assert property (
    sfr_rd && sfr_addr == TLIC_ADDR_LVL |=> !sfr_rdata[7])
    else $error("unimplemented level bit read as one");
  a_secondary_read: assert property (
    sfr_rd && sfr_addr == TLIC_ADDR_SEC && !wr_sec
      |=> sfr_rdata == ({1'b1, $past(sec_ff[6:0])}))
    else $error("secondary register read wrong");
  a_serial_disabled: assert property (
    !sec_ff[TLIC_SER_EN_BIT] |=> irq_vector != TLIC_VEC_SER || !req_ff)
    else $error("disabled serial source was vectored");
  a_high_preempts: assert property (
    lo_ff && !hi_ff && hi_any |=> req_ff && lvl_ff)
    else $error("high request did not preempt low routine");
  a_high_first: assert property (
    hi_any && lo_any |=> lvl_ff)
    else $error("low request served ahead of high");
  a_same_level_held: assert property (
    hi_ff && !core_reti |=> !req_ff)
    else $error("request raised during high routine");
  a_monitor_first: assert property (
    pick[TLIC_S_PSM] |=> vec_ff == TLIC_VEC_PSM)
    else $error("polling order not kept for supply monitor");
  a_ext0_vector: assert property (
    pick == (11'h001 << TLIC_S_EXT0) |=> vec_ff == TLIC_VEC_EXT0)
    else $error("wrong vector for external 0");
  a_watchdog_vector: assert property (
    pick[TLIC_S_WDT] && !pick[TLIC_S_PSM] && !pick[TLIC_S_EXT0]
      |=> vec_ff == TLIC_VEC_WDT)
    else $error("wrong vector for watchdog");
  a_ack_marks_level: assert property (
    accept |=> ($past(lvl_ff) ? hi_ff : lo_ff))
    else $error("accepted level not marked in service");
  a_reti_clears: assert property (
    core_reti && hi_ff && !accept |=> !hi_ff ##0 lo_ff == $past(lo_ff))
    else $error("return did not clear innermost level");

  a_low_same_held: assert property (
    lo_ff && !hi_ff && !core_reti |=> !req_ff || lvl_ff)
    else $error("low request raised during low routine");
  a_monitor_disabled: assert property (
    !sec_ff[TLIC_PSM_EN_BIT] |=> vec_ff != TLIC_VEC_PSM)
    else $error("disabled supply monitor was vectored");
  a_ack_drops_req: assert property (
    accept |=> !req_ff || (lvl_ff && !$past(lvl_ff)))
    else $error("accepted request still raised");

  c_preempt: cover property (lo_ff ##1 hi_ff && lo_ff);
  c_low_accept: cover property (accept && !lvl_ff);
  c_tie_break: cover property ($countones(elig_hi | elig_lo) > 1);
  c_both_levels: cover property (hi_any && lo_any);
  c_nested_return: cover property (hi_ff && lo_ff ##[1:20] !hi_ff && lo_ff);
endmodule

// ==== verif/tlic_core_model.sv ====
// Core model that accepts interrupt requests.
`timescale 1ns/1ps
module tlic_core_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Request from the controller.
  input wire logic irq_push_req,
  // Behaviour set by the bench.
  input wire logic ack_en,
  input wire logic [1:0] ack_wait,
  // Acceptance pulse.
  output logic core_ack
);
  logic [2:0] cnt_ff;
  // Acks a held request once; the gap after it hides a stale request.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 3'h0;
      core_ack <= 1'b0;
    end else if (core_ack) begin
      cnt_ff <= 3'h0;
      core_ack <= 1'b0;
    end else if (irq_push_req && ack_en) begin
      if (cnt_ff == {1'b0, ack_wait} + 3'h1) begin
        core_ack <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end else begin
      cnt_ff <= 3'h0;
    end
  end
endmodule

// ==== verif/two_level_interrupt_controller_tb.sv ====
// Testbench for the two level interrupt controller.
`timescale 1ns/1ps
module two_level_interrupt_controller_tb;
  import tlic_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [14:0] req = 15'h0000;
  logic core_reti = 1'b0;
  logic ack_en = 1'b0;
  logic [1:0] ack_wait = 2'h0;
  logic [7:0] sfr_rdata;
  logic core_ack, irq_push_req, irq_level, in_service_high, in_service_low;
  logic [15:0] irq_vector;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] vec [15] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
    16'h0033, 16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h003B, 16'h0023,
    16'h0023, 16'h002B, 16'h002B, 16'h0053};
  always #50 core_clk = ~core_clk;
  tlic_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .supply_monitor_request(req[0]), .watchdog_request(req[1]),
    .ext0_request(req[2]), .adc_primary_ready(req[3]),
    .adc_aux_ready(req[4]), .timer0_overflow(req[5]),
    .ext1_request(req[6]), .timer1_overflow(req[7]),
    .spi_request(req[8]), .twowire_request(req[9]),
    .uart_rx_flag(req[10]), .uart_tx_flag(req[11]),
    .timer2_overflow(req[12]), .timer2_external_flag(req[13]),
    .interval_counter_request(req[14]), .core_ack(core_ack),
    .core_reti(core_reti), .irq_push_req(irq_push_req),
    .irq_vector(irq_vector), .irq_level(irq_level),
    .in_service_high(in_service_high), .in_service_low(in_service_low));
  tlic_core_model core (.core_clk(core_clk), .reset_n(reset_n),
    .irq_push_req(irq_push_req), .ack_en(ack_en), .ack_wait(ack_wait),
    .core_ack(core_ack));
  // ==========================================================
  // Helpers.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [19:0] st();
    return {in_service_high, in_service_low, irq_push_req, irq_level,
      irq_vector};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    tick(2);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    check({12'h000, sfr_rdata}, {12'h000, exp});
    tick(1);
  endtask
  task automatic reti();
    core_reti = 1'b1;
    tick(1);
    core_reti = 1'b0;
    tick(1);
  endtask
  task automatic wait_is(input logic [1:0] f);
    for (int n = 0; n < 20 && {in_service_high, in_service_low} !== f; n++)
      tick(1);
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic test_regs();
    rd_chk(8'hA8, 8'h00);
    rd_chk(8'hA9, 8'hA0);
    rd_chk(8'hC0, 8'h00);
    rd_chk(8'hB8, 8'h00);
    wr(8'hB8, 8'hFF);
    rd_chk(8'hB8, 8'h7F);
    wr(8'hA9, 8'h77);
    rd_chk(8'hA9, 8'hF7);
    wr(8'hA8, 8'h5A);
    rd_chk(8'hA8, 8'h5A);
    wr(8'hA8, 8'h00);
    wr(8'hB8, 8'h00);
  endtask
  task automatic test_gate();
    req = 15'h0004;
    wr(8'hA8, 8'h01);
    check(st(), 20'h00000);
    wr(8'hA8, 8'h80);
    check(st(), 20'h00000);
    wr(8'hA8, 8'h81);
    check(st(), {4'b0010, 16'h0003});
  endtask
  task automatic test_disable();
    wr(8'hA8, 8'h80);
    wr(8'hA9, 8'h06);
    req = 15'h0300;
    tick(2);
    check(st(), 20'h00000);
    wr(8'hA9, 8'h05);
    req = 15'h0001;
    tick(2);
    check(st(), 20'h00000);
    wr(8'hA9, 8'h07);
    check(st(), {4'b0010, 16'h0043});
  endtask
  task automatic test_order();
    wr(8'hA9, 8'h07);
    wr(8'hA8, 8'hFF);
    for (int i = 0; i < 15; i++) begin
      req = 15'h7FFF << i;
      tick(1);
      check(st(), {4'b0010, vec[i]});
    end
  endtask
  task automatic test_levels();
    wr(8'hB8, 8'h20);
    req = 15'h7FFF;
    tick(1);
    check(st(), {4'b0011, 16'h002B});
    wr(8'hA9, 8'h47);
    check(st(), {4'b0011, 16'h002B});
    wr(8'hB8, 8'h00);
    check(st(), {4'b0011, 16'h0053});
    wr(8'hA9, 8'h17);
    check(st(), {4'b0011, 16'h003B});
    wr(8'hA9, 8'h27);
    check(st(), {4'b0011, 16'h0043});
    req = 15'h0000;
    wr(8'hA9, 8'h07);
  endtask
  task automatic test_nest();
    req = 15'h0020;
    ack_en = 1'b1;
    wait_is(2'b01);
    req = 15'h0040;
    tick(3);
    check(st(), {4'b0100, 16'h0000});
    ack_en = 1'b0;
    wr(8'hB8, 8'h04);
    check(st(), {4'b0111, 16'h0013});
    ack_wait = 2'h3;
    ack_en = 1'b1;
    wait_is(2'b11);
    tick(2);
    check(st(), {4'b1100, 16'h0000});
    req = 15'h0000;
    reti();
    check(st(), {4'b0100, 16'h0000});
    reti();
    check(st(), 20'h00000);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    tick(20);
    reset_n = 1'b1;
    tick(1);
    test_regs();
    test_gate();
    test_disable();
    test_order();
    test_levels();
    test_nest();
    stop_test();
  end
endmodule
